// ===== sew_pkg.sv
// constants shared by the two-wire serial memory block
// How it works
// - small array: 128 pages, 12-bit address
// - large array: 256 pages, 13-bit address
// - data changes only while clock low
// - data falling, clock high: start
// - data rising, clock high: stop, standby
// - acknowledge each received byte on ninth clock
// - standby at reset and after stop
// - device word opens with family pattern
// - next three bits match chip select pins
// - last device bit selects read or write
// - match acknowledges, mismatch returns to standby
// - write protect high blocks all array writes
// - byte write: device, address, data, stop
// - after write stop, program cycle, deaf
// - page write takes up to 31 more
// - writes wrap inside page, low five bits
// - polling acknowledged only after programming ends
// - address counter is last plus one
// - current read sends byte at counter
// - random read: dummy write, then read
// - sequential read continues while controller acknowledges
// - program cycle lasts at most 5 ms
// - sample on rising, change on falling
package sew_pkg;
  localparam int BYTE_BITS = 8;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_BITS = 5;
  localparam int ADDR_W_SMALL = 12;
  localparam int ADDR_W_LARGE = 13;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int FIFO_DEPTH = 16;
  localparam int PROG_TIME_MS = 5;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_MIN_CYCLES = 64;
endpackage

// ===== sew_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module sew_fifo #(
  parameter int W = 13,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sew_fifo_st_t;
  sew_fifo_st_t st;
  sew_fifo_st_t n;
  logic [W-1:0] mem [D];
  logic full;
  logic empty;
  generate
    if (D < 2 || (1 << AW) != D) begin : g_bad
      $error("fifo depth must be a power of two");
    end
  endgenerate
  assign empty = st.wp == st.rp;
  assign full = (st.wp[AW-1:0] == st.rp[AW-1:0]) && (st.wp[AW] != st.rp[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[st.rp[AW-1:0]];
  always_comb begin
    n = st;
    if (in_valid && !full) begin
      n.wp = st.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      n.rp = st.rp + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[st.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// ===== sew_eeprom.sv
// two-wire serial memory: bus slave, page buffer and self-timed programming
`timescale 1ns/100ps
module sew_eeprom import sew_pkg::*; #(
  parameter int ADDR_W = ADDR_W_SMALL,
  parameter int PROG_CYC = PROG_CYCLES
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // two-wire bus
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // straps and protection
  input wire logic [2:0] CHIP_SEL,
  input wire logic WP,
  // status
  output logic PROG_BUSY
);
  localparam int TW = $clog2(PROG_CYC + 1);
  localparam int FW = PAGE_BITS + BYTE_BITS;
  localparam logic [TW-1:0] TLAST = TW'(PROG_CYC - 1);
  localparam logic [5:0] CEND = 6'(PAGE_BYTES);

  generate
    if (ADDR_W != ADDR_W_SMALL && ADDR_W != ADDR_W_LARGE) begin : g_bad_aw
      $error("address width must be 12 or 13");
    end
    if (PROG_CYC < PROG_MIN_CYCLES) begin : g_bad_pc
      $error("program cycle count too small");
    end
  endgenerate

  typedef enum logic [2:0] {S_IDLE, S_DEV, S_AHI, S_ALO, S_WDAT, S_RD, S_PROG} sew_state_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic wp_m;
    logic wp_s;
    logic [2:0] cs_m;
    logic [2:0] cs_s;
    sew_state_t state;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic ackp;
    logic mack;
    logic rdir;
    logic [ADDR_W-1:0] ptr;
    logic wr_any;
    logic wpl;
    logic cm;
    logic [5:0] cidx;
    logic [PAGE_BYTES-1:0] pval;
    logic [TW-1:0] tmr;
    logic oe;
    logic sdo;
    logic push;
    logic [FW-1:0] pdata;
    logic busy;
  } sew_st_t;

  sew_st_t st;
  sew_st_t n;

  // storage array and page latch
  logic [7:0] mem [2**ADDR_W];
  logic [7:0] plat [PAGE_BYTES];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic lat_we;
  logic [7:0] rdata;
  logic do_load;

  // fifo between byte receiver and page latch
  logic f_in_rdy;
  logic f_valid;
  logic [FW-1:0] f_data;
  logic drain_rdy;

  // bus events from synchronised pins
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic match;

  assign rise = st.scl_s & ~st.scl_p;
  assign fall = ~st.scl_s & st.scl_p;
  assign start = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
  assign stop = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
  assign match = (st.sh[7:4] == DEV_TYPE) && (st.sh[3:1] == st.cs_s);
  assign drain_rdy = ~st.cm;
  assign rdata = mem[st.ptr];

  sew_fifo #(
    .W(FW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(NRST),
    .in_valid(st.push),
    .in_ready(f_in_rdy),
    .in_data(st.pdata),
    .out_valid(f_valid),
    .out_ready(drain_rdy),
    .out_data(f_data)
  );

  always_comb begin
    n = st;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    lat_we = 1'b0;
    do_load = 1'b0;
    n.scl_m = SCL;
    n.scl_s = st.scl_m;
    n.scl_p = st.scl_s;
    n.sda_m = SDA_IN;
    n.sda_s = st.sda_m;
    n.sda_p = st.sda_s;
    n.wp_m = WP;
    n.wp_s = st.wp_m;
    n.cs_m = CHIP_SEL;
    n.cs_s = st.cs_m;
    n.push = 1'b0;
    // move buffered bytes into the page latch
    if (f_valid && drain_rdy) begin
      lat_we = 1'b1;
      n.pval[f_data[FW-1:BYTE_BITS]] = 1'b1;
    end
    if (st.state == S_PROG) begin
      // deaf to the bus while programming
      n.oe = 1'b0;
      n.tmr = (st.tmr == TLAST) ? st.tmr : st.tmr + 1'b1;
      if (!st.cm) begin
        if (!f_valid && !st.push) begin
          n.cm = 1'b1;
        end
      end else if (st.cidx != CEND) begin
        // commit latched bytes inside the current page
        if (st.pval[st.cidx[4:0]] && !st.wpl) begin
          mem_we = 1'b1;
          mem_wa = {st.ptr[ADDR_W-1:PAGE_BITS], st.cidx[4:0]};
          mem_wd = plat[st.cidx[4:0]];
        end
        n.pval[st.cidx[4:0]] = 1'b0;
        n.cidx = st.cidx + 1'b1;
      end else if (st.tmr == TLAST) begin
        // program cycle over, back to standby
        n.state = S_IDLE;
        n.cm = 1'b0;
        n.busy = 1'b0;
      end
    end else if (start) begin
      n.state = S_DEV;
      n.bitc = '0;
      n.ackp = 1'b0;
      n.oe = 1'b0;
      n.wr_any = 1'b0;
    end else if (stop) begin
      n.oe = 1'b0;
      n.ackp = 1'b0;
      n.bitc = '0;
      if (st.state == S_WDAT && st.wr_any) begin
        // write ends: start the self-timed cycle
        n.state = S_PROG;
        n.tmr = '0;
        n.cidx = '0;
        n.cm = 1'b0;
        n.wpl = st.wp_s;
        n.busy = 1'b1;
      end else begin
        n.state = S_IDLE;
      end
      n.wr_any = 1'b0;
    end else if (st.state != S_IDLE) begin
      if (rise) begin
        // sample on the rising clock
        if (!st.ackp) begin
          if (st.state != S_RD) begin
            n.sh = {st.sh[6:0], st.sda_s};
          end
          n.bitc = st.bitc + 1'b1;
        end else if (st.state == S_RD) begin
          n.mack = ~st.sda_s;
        end
      end else if (fall) begin
        // every output change on the falling clock
        if (!st.ackp && st.bitc == 4'd8) begin
          n.bitc = '0;
          n.ackp = 1'b1;
          case (st.state)
            S_DEV: begin
              if (match) begin
                n.oe = 1'b1;
                n.rdir = st.sh[0];
              end else begin
                n.state = S_IDLE;
                n.ackp = 1'b0;
              end
            end
            S_AHI: begin
              // unused upper address bits dropped
              n.ptr[ADDR_W-1:8] = st.sh[ADDR_W-9:0];
              n.oe = 1'b1;
            end
            S_ALO: begin
              n.ptr[7:0] = st.sh;
              n.oe = 1'b1;
            end
            S_WDAT: begin
              if (f_in_rdy) begin
                // page-local increment
                n.push = 1'b1;
                n.pdata = {st.ptr[PAGE_BITS-1:0], st.sh};
                n.ptr[PAGE_BITS-1:0] = st.ptr[PAGE_BITS-1:0] + 1'b1;
                n.wr_any = 1'b1;
                n.oe = 1'b1;
              end else begin
                n.state = S_IDLE;
                n.ackp = 1'b0;
              end
            end
            S_RD: begin
              n.oe = 1'b0;
              n.mack = 1'b0;
            end
            default: begin
              n.ackp = 1'b0;
            end
          endcase
        end else if (st.ackp) begin
          n.ackp = 1'b0;
          n.oe = 1'b0;
          case (st.state)
            S_DEV: begin
              if (st.rdir) begin
                do_load = 1'b1;
              end else begin
                n.state = S_AHI;
              end
            end
            S_AHI: begin
              n.state = S_ALO;
            end
            S_ALO: begin
              n.state = S_WDAT;
            end
            S_RD: begin
              if (st.mack) begin
                do_load = 1'b1;
              end else begin
                n.state = S_IDLE;
              end
            end
            default: begin
              n.state = st.state;
            end
          endcase
        end else if (st.state == S_RD) begin
          n.sh = {st.sh[6:0], 1'b0};
          n.oe = ~st.sh[6];
        end
      end
    end
    if (do_load) begin
      // fetch at the counter, counter becomes last plus one
      n.state = S_RD;
      n.sh = rdata;
      n.oe = ~rdata[7];
      n.ptr = st.ptr + 1'b1;
      n.bitc = '0;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (lat_we) begin
      plat[f_data[FW-1:BYTE_BITS]] <= f_data[BYTE_BITS-1:0];
    end
  end

  assign SDA_OUT = st.sdo;
  assign SDA_OE = st.oe;
  assign PROG_BUSY = st.busy;

  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  chk_drive_clock_low: assert property ($changed(st.oe) && !start && !stop |-> !st.scl_s)
    else $error("data line drive changed while clock high");
  chk_start_to_dev: assert property (start && st.state != S_PROG |=> st.state == S_DEV)
    else $error("start not taken");
  chk_stop_read_idle: assert property (stop && st.state != S_PROG
    && !(st.state == S_WDAT && st.wr_any) |=> st.state == S_IDLE)
    else $error("stop after read did not reach standby");
  chk_ack_on_match: assert property (fall && !st.ackp && st.bitc == 4'd8 && st.state == S_DEV
    && match |=> st.oe && st.ackp ##1 st.oe)
    else $error("matching device word not acknowledged");
  chk_silent_mismatch: assert property (fall && !st.ackp && st.bitc == 4'd8 && st.state == S_DEV
    && !match |=> st.state == S_IDLE && !st.oe)
    else $error("mismatch not silent");
  chk_wp_no_write: assert property (mem_we |-> !st.wpl && st.state == S_PROG)
    else $error("array written while protected");
  chk_prog_deaf: assert property (st.state == S_PROG |=> !st.oe)
    else $error("device answered during program cycle");
  chk_page_fixed: assert property (st.push |-> st.ptr[ADDR_W-1:PAGE_BITS]
    == $past(st.ptr[ADDR_W-1:PAGE_BITS]))
    else $error("page bits moved during write");
  chk_read_incr: assert property (do_load |=> st.ptr == $past(st.ptr) + 1'b1)
    else $error("address counter not last plus one");
  chk_prog_bound: assert property (st.state == S_PROG && st.tmr == TLAST && st.cm
    && st.cidx == CEND |=> st.state == S_IDLE && !st.busy)
    else $error("program cycle overran");
  chk_prog_end: assert property (st.state == S_PROG && st.tmr == TLAST
    |-> ##[1:4] !st.busy)
    else $error("program cycle did not end on time");
endmodule

// ===== sew_ctrl_model.sv
// two-wire bus controller model for the serial memory bench
`timescale 1ns/100ps
module sew_ctrl_model (
  // clock
  input wire logic clk,
  // two-wire bus
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one clock, data moved only while clock low
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    tick(2);
    sda_oe = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    r = sda;
  endtask
  task automatic start();
    scl = 1'b0;
    tick(3);
    sda_oe = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b1;
    tick(4);
  endtask
  task automatic stop();
    scl = 1'b0;
    tick(3);
    sda_oe = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask
  // byte out, top bit first, then the acknowledge clock
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, r);
  endtask
  // nine released clocks, then a start
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) bit_io(1'b1, r);
    start();
  endtask
endmodule

// ===== sew_eeprom_bench.sv
// self-checking bench for the two-wire serial memory block
`timescale 1ns/100ps
module sew_eeprom_bench;
  localparam logic [2:0] CS = 3'h5;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic wp = 1'b0;
  logic sda_out, sda_oe, busy, scl, ctrl_oe;
  // pulled up while nobody drives low
  wire sda = !(sda_oe | ctrl_oe);
  logic [7:0] ref_mem [4096];
  int miscompares = 0;
  int checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  sew_eeprom #(.ADDR_W(12), .PROG_CYC(200)) sew_eeprom_inst (
    .REF_CLK(ref_clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .CHIP_SEL(CS), .WP(wp), .PROG_BUSY(busy)
  );
  sew_ctrl_model sew_ctrl_model_inst (.clk(ref_clk), .scl(scl), .sda_oe(ctrl_oe), .sda(sda));
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic snd(input logic [7:0] d, input logic exp_ack);
    logic a;
    sew_ctrl_model_inst.send(d, a);
    check({7'h0, a}, {7'h0, exp_ack}, "acknowledge");
  endtask
  task automatic head(input logic [11:0] a);
    sew_ctrl_model_inst.start();
    snd({sew_pkg::DEV_TYPE, CS, 1'b0}, 1'b1);
    snd({4'ha, a[11:8]}, 1'b1);
    snd(a[7:0], 1'b1);
  endtask
  task automatic wr(input logic [11:0] a, input int n, input logic [7:0] d0);
    logic ok;
    head(a);
    for (int i = 0; i < n; i++) begin
      snd(d0 + 8'(i), 1'b1);
      if (!wp) ref_mem[{a[11:5], a[4:0] + 5'(i)}] = d0 + 8'(i);
    end
    sew_ctrl_model_inst.stop();
    sew_ctrl_model_inst.tick(4);
    check({7'h0, busy}, 8'h1, "busy after stop");
    sew_ctrl_model_inst.start();
    snd({sew_pkg::DEV_TYPE, CS, 1'b0}, 1'b0);
    ok = 1'b0;
    for (int k = 0; k < 20 && !ok; k++) begin
      sew_ctrl_model_inst.stop();
      sew_ctrl_model_inst.start();
      sew_ctrl_model_inst.send({sew_pkg::DEV_TYPE, CS, 1'b0}, ok);
    end
    check({7'h0, ok}, 8'h1, "poll acknowledged");
    check({7'h0, busy}, 8'h0, "busy at poll acknowledge");
    sew_ctrl_model_inst.stop();
  endtask
  task automatic rd(input logic [11:0] a, input int n, input logic rnd);
    logic [7:0] d;
    if (rnd) head(a);
    sew_ctrl_model_inst.start();
    snd({sew_pkg::DEV_TYPE, CS, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      sew_ctrl_model_inst.recv(i != n - 1, d);
      check(d, ref_mem[a + 12'(i)], "read data");
    end
    sew_ctrl_model_inst.stop();
  endtask
  task automatic t_bad();
    logic [7:0] bad [2];
    bad[0] = {sew_pkg::DEV_TYPE, ~CS, 1'b0};
    bad[1] = {sew_pkg::DEV_TYPE ^ 4'h1, CS, 1'b1};
    for (int i = 0; i < 2; i++) begin
      sew_ctrl_model_inst.start();
      snd(bad[i], 1'b0);
      snd(8'h00, 1'b0);
      sew_ctrl_model_inst.stop();
    end
    check({7'h0, sda_out}, 8'h0, "open drain level");
    check({7'h0, sda_oe}, 8'h0, "data line released");
    $display("test address mismatch done");
  endtask
  task automatic t_byte();
    wr(12'h123, 1, 8'h5a);
    rd(12'h123, 1, 1'b1);
    $display("test byte write and random read done");
  endtask
  task automatic t_page();
    wr(12'h0fc, 33, 8'h10);
    rd(12'h0e0, 32, 1'b1);
    $display("test page write wrap done");
  endtask
  task automatic t_wrap();
    wr(12'hfff, 1, 8'hc3);
    wr(12'h000, 1, 8'h3c);
    rd(12'hfff, 1, 1'b1);
    rd(12'h000, 1, 1'b0);
    rd(12'hfff, 2, 1'b1);
    $display("test array wrap done");
  endtask
  task automatic t_wp();
    wp = 1'b1;
    wr(12'h123, 1, 8'ha5);
    wp = 1'b0;
    rd(12'h123, 1, 1'b1);
    $display("test write protect done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 nrst = 1'b1;
    sew_ctrl_model_inst.tick(4);
    sew_ctrl_model_inst.recover();
    sew_ctrl_model_inst.stop();
    t_bad();
    t_byte();
    t_page();
    t_wrap();
    t_wp();
    print_verdict();
  end
  // watchdog
  initial begin
    #2000000;
    miscompares++;
    $display("wrong value at %0t ns: run did not finish", $time);
    print_verdict();
  end
endmodule
